// *** rtl/cir_regs.v ***
// Functional notes
// - identity upper sixteen bits read zero
// - fixed implementation code in bits 15:8
// - fixed revision number in bits 7:0
// - only wait, cache-off, policy bits writable
// - ratio, byte order latched at reset, read-only
// - bits 30:28 report bus clock divisor
// - bit 18 selects halt or doze
// - pipeline stalls in halt and doze
// - snoops served in doze, not halt
// - bit 17 disables instruction cache
// - bit 16 disables data cache
// - bits 11:9 read 011
// - bits 8:6 read 011
// - bits 5 and 4 read one
// - bits 2:0 kernel segment policy, reset zero
`timescale 1ns/100ps
module cir_regs #(
  parameter [7:0] IMPL_CODE = 8'h5A, // arbitrary value
  parameter [7:0] REVISION = 8'h01 // arbitrary value
) (
  input wire clock_i,
  input wire rstn_i,
  // ahb-lite slave
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output reg [31:0] hrdata_o,
  output wire hreadyout_o,
  output wire hresp_o,
  // strap pins
  input wire [2:0] gbus_divide_ratio_pin_i,
  input wire byte_order_pin_i,
  // core side
  input wire wait_exec_i,
  input wire wake_i,
  input wire snoop_req_i,
  output wire pipe_stall_o,
  output wire snoop_grant_o,
  output wire halted_o,
  output wire dozing_o,
  output wire instr_cache_off_o,
  output wire data_cache_off_o,
  output wire [2:0] kernel_segment_cache_policy_o,
  output wire [2:0] gbus_divide_ratio_o,
  output wire byte_order_o,
  output wire straps_valid_o
);
`include "cir_map.vh"

// software-writable fields
reg wait_mode_ff;
reg instr_cache_off_ff;
reg data_cache_off_ff;
reg [2:0] kseg_policy_ff;

// their next values, also the source of a forwarded read
reg nxt_wait_mode;
reg nxt_instr_cache_off;
reg nxt_data_cache_off;
reg [2:0] nxt_kseg_policy;

// data-phase bookkeeping
reg wr_pend_ff;
reg [7:0] wr_ofs_ff;
reg [31:0] nxt_rdata;

// hardware-latched fields
wire [2:0] gbus_divide_ratio;
wire byte_order;

// assembled register images
reg [31:0] ident_word;
reg [31:0] options_word;

// bus decode
wire addr_phase;
wire wr_now;
wire [7:0] req_ofs;

// window hit and write strobes
wire in_window;
wire word_wr;
wire rd_hit;
wire opt_wr_en;

// strap pins pass two flops, then are held; a pin that moves
// after the first edge past reset release never reaches software;
// the read-only fields read zero until latched, then hold steady
cir_strap_latch u_straps (
  .clock_i(clock_i),
  .rstn_i(rstn_i),
  .div_pin_i(gbus_divide_ratio_pin_i),
  .bord_pin_i(byte_order_pin_i),
  .div_o(gbus_divide_ratio),
  .bord_o(byte_order),
  .done_o(straps_valid_o)
);

// wait-instruction power-down sequencer; the mode bit is passed
// live and only sampled when the wait instruction executes
cir_wait_ctl u_wait (
  .clock_i(clock_i),
  .rstn_i(rstn_i),
  .wait_mode_i(wait_mode_ff),
  .wait_exec_i(wait_exec_i),
  .wake_i(wake_i),
  .snoop_req_i(snoop_req_i),
  .pipe_stall_o(pipe_stall_o),
  .snoop_grant_o(snoop_grant_o),
  .halted_o(halted_o),
  .dozing_o(dozing_o)
);

// zero-wait-state slave, always okay
// every register is a flop or a constant, so no stall is needed
assign hreadyout_o = 1'b1;
assign hresp_o = 1'b0;

// a transfer is taken on a selected nonseq or seq address phase
assign addr_phase = hsel_i & htrans_i[1] & hready_i;
assign req_ofs = haddr_i[7:0];
assign wr_now = wr_pend_ff;

// only the low byte decodes; anything above it misses the block
assign in_window = (haddr_i[31:8] == 24'h000000);

assign word_wr = addr_phase & hwrite_i & (hsize_i == 3'h2) & in_window;

// reads answer in the cycle after the address phase
assign rd_hit = addr_phase & ~hwrite_i & in_window;

// remember a word write for its data phase
// the offset is kept too, since haddr moves on in the data phase
always @(posedge clock_i or negedge rstn_i) begin
  if (!rstn_i) begin
    wr_pend_ff <= 1'b0;
    wr_ofs_ff <= 8'h00;
  end else if (hready_i) begin
    wr_pend_ff <= word_wr;
    wr_ofs_ff <= req_ofs;
  end
end

// options write strobe: data phase of a taken word write; a read
// in that same cycle is served from the next values below
assign opt_wr_en = wr_now & (wr_ofs_ff == `CIR_OPTIONS_OFS);

always @* begin
  nxt_wait_mode = wait_mode_ff;
  if (opt_wr_en) begin
    nxt_wait_mode = hwdata_i[`CIR_OPT_WAIT_BIT];
  end
end

always @* begin
  nxt_instr_cache_off = instr_cache_off_ff;
  if (opt_wr_en) begin
    nxt_instr_cache_off = hwdata_i[`CIR_OPT_IOFF_BIT];
  end
end

always @* begin
  nxt_data_cache_off = data_cache_off_ff;
  if (opt_wr_en) begin
    nxt_data_cache_off = hwdata_i[`CIR_OPT_DOFF_BIT];
  end
end

always @* begin
  nxt_kseg_policy = kseg_policy_ff;
  if (opt_wr_en) begin
    nxt_kseg_policy = hwdata_i[`CIR_OPT_KSEG_HI:`CIR_OPT_KSEG_LO];
  end
end

always @(posedge clock_i or negedge rstn_i) begin
  if (!rstn_i) begin
    wait_mode_ff <= `CIR_WAIT_RST;
  end else begin
    wait_mode_ff <= nxt_wait_mode;
  end
end

always @(posedge clock_i or negedge rstn_i) begin
  if (!rstn_i) begin
    instr_cache_off_ff <= `CIR_IOFF_RST;
  end else begin
    instr_cache_off_ff <= nxt_instr_cache_off;
  end
end

always @(posedge clock_i or negedge rstn_i) begin
  if (!rstn_i) begin
    data_cache_off_ff <= `CIR_DOFF_RST;
  end else begin
    data_cache_off_ff <= nxt_data_cache_off;
  end
end

always @(posedge clock_i or negedge rstn_i) begin
  if (!rstn_i) begin
    kseg_policy_ff <= `CIR_KSEG_RST;
  end else begin
    kseg_policy_ff <= nxt_kseg_policy;
  end
end

// identity word, pure constants, so writes to it fall away
// and a read never depends on reset timing
always @* begin
  ident_word = 32'h00000000;
  ident_word[`CIR_ID_IMPL_HI:`CIR_ID_IMPL_LO] = IMPL_CODE;
  ident_word[`CIR_ID_REV_HI:`CIR_ID_REV_LO] = REVISION;
end

// options word, built from next values so a read just after a
// write sees the new contents
always @* begin
  options_word = 32'h00000000;
  options_word[`CIR_OPT_DIV_HI:`CIR_OPT_DIV_LO] = gbus_divide_ratio;
  options_word[`CIR_OPT_WAIT_BIT] = nxt_wait_mode;
  options_word[`CIR_OPT_IOFF_BIT] = nxt_instr_cache_off;
  options_word[`CIR_OPT_DOFF_BIT] = nxt_data_cache_off;
  options_word[`CIR_OPT_BORD_BIT] = byte_order;
  options_word[`CIR_OPT_ONES_HI:`CIR_OPT_ONES_LO] = `CIR_ONES_VAL;
  options_word[`CIR_OPT_ICAP_HI:`CIR_OPT_ICAP_LO] = `CIR_ICAP_VAL;
  options_word[`CIR_OPT_DCAP_HI:`CIR_OPT_DCAP_LO] = `CIR_DCAP_VAL;
  options_word[`CIR_OPT_ILINE_BIT] = `CIR_LINE_VAL;
  options_word[`CIR_OPT_DLINE_BIT] = `CIR_LINE_VAL;
  options_word[`CIR_OPT_KSEG_HI:`CIR_OPT_KSEG_LO] = nxt_kseg_policy;
end

// read mux, unmapped addresses read zero
// the word is chosen in the address phase and held a cycle
always @* begin
  nxt_rdata = 32'h00000000;
  if (rd_hit) begin
    case (req_ofs)
      `CIR_IDENT_OFS: begin
        nxt_rdata = ident_word;
      end
      `CIR_OPTIONS_OFS: begin
        nxt_rdata = options_word;
      end
      default: begin
        nxt_rdata = 32'h00000000;
      end
    endcase
  end
end

// read data registered for the data phase; it holds while the bus
// stalls, so a slow master still sees the word
always @(posedge clock_i or negedge rstn_i) begin
  if (!rstn_i) begin
    hrdata_o <= 32'h00000000;
  end else if (hready_i) begin
    hrdata_o <= nxt_rdata;
  end
end

// controls out to the core, straight from their flops
// instruction cache disable
assign instr_cache_off_o = instr_cache_off_ff;
assign data_cache_off_o = data_cache_off_ff;
assign kernel_segment_cache_policy_o = kseg_policy_ff;
assign gbus_divide_ratio_o = gbus_divide_ratio;
assign byte_order_o = byte_order;

endmodule // cir_regs

// *** rtl/cir_map.vh ***
`ifndef CIR_MAP_VH
`define CIR_MAP_VH

// register byte offsets on the bus
`define CIR_IDENT_OFS 8'h00
`define CIR_OPTIONS_OFS 8'h04

// identity register layout
`define CIR_ID_IMPL_HI 15
`define CIR_ID_IMPL_LO 8
`define CIR_ID_REV_HI 7
`define CIR_ID_REV_LO 0

// options register layout
`define CIR_OPT_DIV_HI 30
`define CIR_OPT_DIV_LO 28
`define CIR_OPT_WAIT_BIT 18
`define CIR_OPT_IOFF_BIT 17
`define CIR_OPT_DOFF_BIT 16
`define CIR_OPT_BORD_BIT 15
`define CIR_OPT_ONES_HI 14
`define CIR_OPT_ONES_LO 13
`define CIR_OPT_ICAP_HI 11
`define CIR_OPT_ICAP_LO 9
`define CIR_OPT_DCAP_HI 8
`define CIR_OPT_DCAP_LO 6
`define CIR_OPT_ILINE_BIT 5
`define CIR_OPT_DLINE_BIT 4
`define CIR_OPT_KSEG_HI 2
`define CIR_OPT_KSEG_LO 0

// fixed and reset values
`define CIR_ONES_VAL 2'h3
`define CIR_ICAP_VAL 3'h3
`define CIR_DCAP_VAL 3'h3
`define CIR_LINE_VAL 1'h1
`define CIR_WAIT_RST 1'h0
`define CIR_IOFF_RST 1'h0
`define CIR_DOFF_RST 1'h0
`define CIR_KSEG_RST 3'h0
`define CIR_DIV_RST 3'h0
`define CIR_BORD_RST 1'h0

// wait-mode encoding
`define CIR_WAIT_HALT 1'h0
`define CIR_WAIT_DOZE 1'h1

// cycles after reset release before straps are latched
`define CIR_STRAP_SETTLE 2'h2

`endif

// *** rtl/cir_strap_latch.v ***
`timescale 1ns/100ps
// synchronises strap pins and latches them once after reset release
module cir_strap_latch (
  input wire clock_i,
  input wire rstn_i,
  input wire [2:0] div_pin_i,
  input wire bord_pin_i,
  output reg [2:0] div_o,
  output reg bord_o,
  output reg done_o
);
`include "cir_map.vh"

reg [3:0] sync1_ff;
reg [3:0] sync2_ff;
reg [1:0] settle_ff;

// two-flop synchroniser for the pins
always @(posedge clock_i or negedge rstn_i) begin
  if (!rstn_i) begin
    sync1_ff <= 4'h0;
    sync2_ff <= 4'h0;
  end else begin
    sync1_ff <= {bord_pin_i, div_pin_i};
    sync2_ff <= sync1_ff;
  end
end

// latch once the synchroniser holds settled pin levels
always @(posedge clock_i or negedge rstn_i) begin
  if (!rstn_i) begin
    settle_ff <= 2'h0;
    done_o <= 1'b0;
    div_o <= `CIR_DIV_RST;
    bord_o <= `CIR_BORD_RST;
  end else if (!done_o) begin
    if (settle_ff == `CIR_STRAP_SETTLE) begin
      div_o <= sync2_ff[2:0];
      bord_o <= sync2_ff[3];
      done_o <= 1'b1;
    end else begin
      settle_ff <= settle_ff + 2'h1;
    end
  end
end

endmodule // cir_strap_latch

// *** rtl/cir_wait_ctl.v ***
`timescale 1ns/100ps
// power-down sequencer entered by the wait instruction
module cir_wait_ctl (
  input wire clock_i,
  input wire rstn_i,
  input wire wait_mode_i,
  input wire wait_exec_i,
  input wire wake_i,
  input wire snoop_req_i,
  output wire pipe_stall_o,
  output wire snoop_grant_o,
  output wire halted_o,
  output wire dozing_o
);
`include "cir_map.vh"

localparam ST_RUN = 2'h0;
localparam ST_HALT = 2'h1;
localparam ST_DOZE = 2'h2;

reg [1:0] state_ff;
reg [1:0] nxt_state;

// next state: mode is sampled when the wait instruction executes
always @* begin
  nxt_state = state_ff;
  case (state_ff)
    ST_RUN: begin
      if (wait_exec_i) begin
        if (wait_mode_i == `CIR_WAIT_DOZE) begin
          nxt_state = ST_DOZE;
        end else begin
          nxt_state = ST_HALT;
        end
      end
    end
    ST_HALT, ST_DOZE: begin
      if (wake_i) begin
        nxt_state = ST_RUN;
      end
    end
    default: begin
      nxt_state = ST_RUN;
    end
  endcase
end

always @(posedge clock_i or negedge rstn_i) begin
  if (!rstn_i) begin
    state_ff <= ST_RUN;
  end else begin
    state_ff <= nxt_state;
  end
end

assign pipe_stall_o = (state_ff != ST_RUN);
assign snoop_grant_o = snoop_req_i & (state_ff != ST_HALT);
assign halted_o = (state_ff == ST_HALT);
assign dozing_o = (state_ff == ST_DOZE);

endmodule // cir_wait_ctl

// *** test/cir_regs_chk.sv ***
`timescale 1ns/100ps
module cir_regs_chk #(
  parameter [7:0] IMPL_CODE = 8'h5A,
  parameter [7:0] REVISION = 8'h01
) (
  input wire clock_i,
  input wire rstn_i,
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  input wire [31:0] hrdata_o,
  input wire hreadyout_o,
  input wire hresp_o,
  input wire wake_i,
  input wire wait_exec_i,
  input wire snoop_req_i,
  input wire pipe_stall_o,
  input wire snoop_grant_o,
  input wire halted_o,
  input wire dozing_o,
  input wire instr_cache_off_o,
  input wire data_cache_off_o,
  input wire [2:0] kernel_segment_cache_policy_o,
  input wire [2:0] gbus_divide_ratio_o,
  input wire byte_order_o,
  input wire straps_valid_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  // taken read and taken word write to the options word
  wire rd = hsel_i && htrans_i[1] && hready_i && !hwrite_i;
  wire wr4 = hsel_i && htrans_i[1] && hready_i && hwrite_i &&
    haddr_i == 32'h4 && hsize_i == 3'h2;
  chk_bus_okay: assert property (hreadyout_o && !hresp_o)
    else $error("bus not ready or not okay");
  chk_ident_value: assert property (rd && haddr_i == 32'h0 |=>
    hrdata_o == {16'h0, IMPL_CODE, REVISION}) else $error("identity wrong");
  chk_fixed_bits: assert property (
    rd && haddr_i == 32'h4 |=>
    (hrdata_o & 32'h8FF87FF8) == 32'h000066F0) else $error("fixed bits wrong");
  chk_opts_mirror: assert property (rd && haddr_i == 32'h4 &&
    straps_valid_o |=> hrdata_o[30:28] == gbus_divide_ratio_o &&
    hrdata_o[17:15] == {instr_cache_off_o, data_cache_off_o, byte_order_o}
    && hrdata_o[2:0] == kernel_segment_cache_policy_o)
    else $error("options read differs from outputs");
  chk_write_ctl: assert property (wr4 ##1 1 |=>
    {14'h0, instr_cache_off_o, data_cache_off_o, 13'h0,
    kernel_segment_cache_policy_o} == ($past(hwdata_i) & 32'h00030007))
    else $error("control write lost");
  chk_wait_entry: assert property (wait_exec_i && !pipe_stall_o &&
    !wake_i |=> pipe_stall_o && (halted_o != dozing_o))
    else $error("wait not entered");
  chk_stall_state: assert property (
    pipe_stall_o == (halted_o || dozing_o) && !(halted_o && dozing_o))
    else $error("stall mismatch");
  chk_snoop_gate: assert property (
    snoop_grant_o == (snoop_req_i && !halted_o))
    else $error("snoop grant wrong");
  chk_wake_exit: assert property (
    pipe_stall_o && wake_i |=> !pipe_stall_o)
    else $error("wake ignored");
  chk_mode_hold: assert property (pipe_stall_o && !wake_i |=>
    $stable({halted_o, dozing_o})) else $error("power state drifted");
  chk_strap_hold: assert property (straps_valid_o |=> straps_valid_o &&
    $stable({gbus_divide_ratio_o, byte_order_o})) else $error("straps moved");
endmodule // cir_regs_chk

bind cir_regs cir_regs_chk #(.IMPL_CODE(IMPL_CODE), .REVISION(REVISION)) u_chk (
  .clock_i, .rstn_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i,
  .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .wake_i,
  .wait_exec_i, .snoop_req_i, .pipe_stall_o, .snoop_grant_o, .halted_o,
  .dozing_o, .instr_cache_off_o, .data_cache_off_o,
  .kernel_segment_cache_policy_o, .gbus_divide_ratio_o, .byte_order_o,
  .straps_valid_o);

// *** test/cir_regs_bench.sv ***
`timescale 1ns/100ps
module cir_regs_bench;
  localparam [7:0] IMPL = 8'hA5; // arbitrary value
  localparam [7:0] REV = 8'h3C; // arbitrary value
  reg clock_i = 1'h0, rstn_i = 1'h0, hsel_i = 1'h0, hwrite_i = 1'h0;
  reg byte_order_pin_i = 1'h0, wait_exec_i = 1'h0, wake_i = 1'h0;
  reg snoop_req_i = 1'h0;
  reg [1:0] htrans_i = 2'h0;
  reg [2:0] hsize_i = 3'h2, gbus_divide_ratio_pin_i = 3'h0;
  reg [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, rd;
  wire hready_i, hreadyout_o, hresp_o, pipe_stall_o, snoop_grant_o;
  wire halted_o, dozing_o, instr_cache_off_o, data_cache_off_o;
  wire byte_order_o, straps_valid_o;
  wire [2:0] kernel_segment_cache_policy_o, gbus_divide_ratio_o;
  wire [31:0] hrdata_o;
  integer fail_count = 0, check_count = 0;
  assign hready_i = hreadyout_o;
  always #2 clock_i = ~clock_i;
  cir_regs #(.IMPL_CODE(IMPL), .REVISION(REV)) dut (
    .clock_i, .rstn_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i,
    .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o,
    .gbus_divide_ratio_pin_i, .byte_order_pin_i, .wait_exec_i, .wake_i,
    .snoop_req_i, .pipe_stall_o, .snoop_grant_o, .halted_o, .dozing_o,
    .instr_cache_off_o, .data_cache_off_o, .kernel_segment_cache_policy_o,
    .gbus_divide_ratio_o, .byte_order_o, .straps_valid_o);
  task chk(input [31:0] got, input [31:0] exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one single transfer of size sz, read data kept in rd
  task bus(input [31:0] a, input w, input [2:0] sz, input [31:0] wd);
    hsel_i <= 1'h1;
    haddr_i <= a;
    hwrite_i <= w;
    htrans_i <= 2'h2;
    hsize_i <= sz;
    @(posedge clock_i);
    while (hready_i !== 1'h1) @(posedge clock_i);
    hsel_i <= 1'h0;
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    @(posedge clock_i);
    while (hready_i !== 1'h1) @(posedge clock_i);
    rd = hrdata_o;
  endtask
  task do_reset;
    rstn_i <= 1'h0;
    repeat (16) @(posedge clock_i);
    rstn_i <= 1'h1;
    @(posedge clock_i);
    while (straps_valid_o !== 1'h1) @(posedge clock_i);
  endtask
  // each ratio code and byte order latched at reset, pins then ignored
  task t_straps;
    integer k;
    for (k = 0; k < 8; k = k + 1) begin
      gbus_divide_ratio_pin_i <= k[2:0]; // all codes, full variant
      byte_order_pin_i <= k[0];
      do_reset;
      gbus_divide_ratio_pin_i <= ~k[2:0];
      byte_order_pin_i <= ~k[0];
      repeat (4) @(posedge clock_i);
      bus(32'h4, 1'h0, 3'h2, 32'h0);
      chk(rd, 32'h66F0 | k << 28 | k[0] << 15);
      chk({gbus_divide_ratio_o, byte_order_o}, {k[2:0], k[0]});
    end
  endtask
  // identity is fixed and ignores writes
  task t_ident;
    bus(32'h0, 1'h1, 3'h2, 32'hFFFFFFFF);
    bus(32'h0, 1'h0, 3'h2, 32'h0);
    chk(rd, {16'h0, IMPL, REV});
  endtask
  // only control bits take writes; byte and stray writes dropped
  task t_opts;
    integer k;
    bus(32'h4, 1'h1, 3'h2, 32'hFFFFFFFF);
    bus(32'h4, 1'h1, 3'h0, 32'h0);
    bus(32'h104, 1'h1, 3'h2, 32'h0);
    bus(32'h4, 1'h0, 3'h2, 32'h0);
    chk(rd, 32'h7007E6F7);
    chk({instr_cache_off_o, data_cache_off_o}, 2'h3);
    bus(32'h8, 1'h0, 3'h2, 32'h0);
    chk(rd, 32'h0);
    for (k = 0; k < 8; k = k + 1) begin
      bus(32'h4, 1'h1, 3'h2, k);
      bus(32'h4, 1'h0, 3'h2, 32'h0);
      chk(rd, 32'h7000E6F0 | k);
      chk(kernel_segment_cache_policy_o, k);
    end
  endtask
  // wait enters halt or doze by mode bit, snoops granted in doze and run, not halt
  task t_wait;
    integer k;
    snoop_req_i <= 1'h1;
    for (k = 0; k < 2; k = k + 1) begin
      bus(32'h4, 1'h1, 3'h2, k << 18);
      @(posedge clock_i);
      wait_exec_i <= 1'h1;
      @(posedge clock_i);
      wait_exec_i <= 1'h0;
      @(posedge clock_i);
      chk({pipe_stall_o, halted_o, dozing_o, snoop_grant_o},
        k ? 4'hB : 4'hC);
      wake_i <= 1'h1;
      @(posedge clock_i);
      wake_i <= 1'h0;
      @(posedge clock_i);
      chk({pipe_stall_o, halted_o, dozing_o, snoop_grant_o}, 4'h1);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // main sequence
  initial begin
    t_straps;
    t_ident;
    t_opts;
    t_wait;
    tally_and_finish;
  end
  // hang guard, tests need under 1000 cycles
  initial begin
    #20000;
    fail_count = fail_count + 1;
    tally_and_finish;
  end
endmodule // cir_regs_bench
